// ### common/gbr_pkg.sv
// Purpose: shared constants and types of the pin and bus-master register bank
// Assumes: 40 MHz system clock, half of a 7.3728 MHz reference rebuilt by a fractional divider
// Notes: offsets are the byte addresses of the register access port
package gbr_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_MODE_LO = 8'h02;
	localparam logic [7:0] OFS_MODE_HI = 8'h03;
	localparam logic [7:0] OFS_PIN_LEVEL = 8'h04;
	localparam logic [7:0] OFS_OWN_ADDR = 8'h06;
	localparam logic [7:0] OFS_SCL_LOW = 8'h07;
	localparam logic [7:0] OFS_SCL_HIGH = 8'h08;
	localparam logic [7:0] OFS_TIMEOUT = 8'h09;
	localparam logic [7:0] OFS_RESULT = 8'h0A;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_PIN_LATCH = 8'hFF;
	localparam logic [7:0] RST_OWN_ADDR = 8'h00;
	localparam logic [7:0] RST_SCL_COUNT = 8'h0A;
	localparam logic [7:0] RST_TIMEOUT = 8'h00;
	// ----------------------------------------
	// field layouts and codes
	// ----------------------------------------
	localparam int TO_EN_BIT = 0;
	localparam logic [1:0] MODE_QUASI = 2'h0;
	localparam logic [1:0] MODE_INPUT = 2'h1;
	localparam logic [1:0] MODE_PUSH = 2'h2;
	localparam logic [1:0] MODE_OPEN = 2'h3;
	localparam logic [3:0] RESULT_FILL = 4'hF;
	localparam logic [3:0] RES_OK = 4'h0;
	localparam logic [3:0] RES_ADDR_REFUSED = 4'h1;
	localparam logic [3:0] RES_DATA_REFUSED = 4'h2;
	localparam logic [3:0] RES_TIMEOUT = 4'h8;
	// ----------------------------------------
	// timing: half-rate reference tick, time-out prescale
	// ----------------------------------------
	localparam int CLK_HZ = 40000000;
	localparam int REF_HZ = 7372800;
	localparam logic [25:0] HALF_INC = 26'(REF_HZ / 2);
	localparam logic [25:0] ACC_MOD = 26'(CLK_HZ);
	localparam logic [5:0] TO_PRESCALE = 6'h3F;
	localparam logic [8:0] MIN_SCL_SUM = 9'h00A;
	localparam logic [7:0] MIN_SCL_HALF = 8'h05;
	localparam logic [3:0] ACK_BIT = 4'h8;
	// ----------------------------------------
	// bus master states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_LOW = 3'b010,
		ST_HIGH = 3'b011,
		ST_STOP_L = 3'b100,
		ST_STOP_H = 3'b101
	} gbr_state_t;
endpackage : gbr_pkg

// ### hw/gbr_regs.sv
// Purpose: pin drive modes, pin level register and two-wire master with its settings
// Assumes: command parser outside gives register strobes; pins pass two flip-flops
// Notes: master writes one address byte then, if the slave acks it, one data byte per transfer
`timescale 1ns/100ps
module gbr_regs (
	input wire logic CLK, // system clock
	input wire logic SYS_RST, // synchronous reset, active high
	input wire logic REG_WE, // register write strobe
	input wire logic REG_RE, // register read strobe
	input wire logic [7:0] REG_ADDR, // register offset
	input wire logic [7:0] REG_WDATA, // write data
	output logic [7:0] REG_RDATA, // read data
	output logic REG_RVALID, // read data valid pulse
	input wire logic XFER_GO, // start transfer pulse
	input wire logic [7:0] XFER_SLAVE, // address byte sent first
	input wire logic [7:0] XFER_DATA, // data byte sent second
	output logic XFER_BUSY, // transfer in progress
	input wire logic [7:0] GPIO_IN, // pin levels
	output logic [7:0] GPIO_OUT, // pin drive value
	output logic [7:0] GPIO_OE, // strong drive enable
	output logic [7:0] GPIO_PU, // weak pull-up enable
	input wire logic SCL_IN, // clock line level
	output logic SCL_OUT, // clock line drive value
	output logic SCL_OE, // clock line pull low
	input wire logic SDA_IN, // data line level
	output logic SDA_OUT, // data line drive value
	output logic SDA_OE // data line pull low
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [15:0] mode_r, mode_nxt;
	logic [7:0] latch_r, latch_nxt;
	logic [7:0] own_r, own_nxt;
	logic [7:0] sclh_r, sclh_nxt;
	logic [7:0] scll_r, scll_nxt;
	logic [7:0] to_r, to_nxt;
	logic [3:0] stat_r, stat_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [7:0] gpio_s1_r, gpio_s2_r;
	logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;
	logic [7:0] gout_r, gout_nxt, goe_r, goe_nxt, gpu_r, gpu_nxt;
	logic [25:0] acc_r, acc_nxt;
	logic half_tick_r, half_tick_nxt;
	logic [5:0] pre_r, pre_nxt;
	logic to_tick_r, to_tick_nxt;
	gbr_pkg::gbr_state_t st_r, st_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [7:0] shf_r, shf_nxt;
	logic [7:0] dat_r, dat_nxt;
	logic byte_r, byte_nxt;
	logic [3:0] res_r, res_nxt;
	logic scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
	logic [14:0] tmo_r, tmo_nxt;
	logic [7:0] hi_cnt, lo_cnt;
	logic [8:0] scl_sum;
	logic busy_r, busy_nxt;

	// pin mode of one pin from the two mode registers
	function automatic logic [1:0] pin_mode(input logic [15:0] modes, input int idx);
		pin_mode = modes[2*idx +: 2];
	endfunction : pin_mode

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// two flops on every pin before any logic
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			gpio_s1_r <= 8'h00;
			gpio_s2_r <= 8'h00;
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
		end else begin
			gpio_s1_r <= GPIO_IN;
			gpio_s2_r <= gpio_s1_r;
			scl_s1_r <= SCL_IN;
			scl_s2_r <= scl_s1_r;
			sda_s1_r <= SDA_IN;
			sda_s2_r <= sda_s1_r;
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	// writes and reads; the result register is updated by the bus master
	always_comb begin
		mode_nxt = mode_r;
		latch_nxt = latch_r;
		own_nxt = own_r;
		sclh_nxt = sclh_r;
		scll_nxt = scll_r;
		to_nxt = to_r;
		rdata_nxt = rdata_r;
		rvalid_nxt = REG_RE;
		if (REG_WE) begin
			case (REG_ADDR)
				gbr_pkg::OFS_MODE_LO: mode_nxt[7:0] = REG_WDATA;
				gbr_pkg::OFS_MODE_HI: mode_nxt[15:8] = REG_WDATA;
				gbr_pkg::OFS_PIN_LEVEL: latch_nxt = REG_WDATA;
				gbr_pkg::OFS_OWN_ADDR: own_nxt = REG_WDATA;
				gbr_pkg::OFS_SCL_LOW: scll_nxt = REG_WDATA;
				gbr_pkg::OFS_SCL_HIGH: sclh_nxt = REG_WDATA;
				gbr_pkg::OFS_TIMEOUT: to_nxt = REG_WDATA;
				default: ;
			endcase
		end
		if (REG_RE) begin
			case (REG_ADDR)
				gbr_pkg::OFS_MODE_LO: rdata_nxt = mode_r[7:0];
				gbr_pkg::OFS_MODE_HI: rdata_nxt = mode_r[15:8];
				gbr_pkg::OFS_PIN_LEVEL: rdata_nxt = gpio_s2_r;
				gbr_pkg::OFS_OWN_ADDR: rdata_nxt = own_r;
				gbr_pkg::OFS_SCL_LOW: rdata_nxt = scll_r;
				gbr_pkg::OFS_SCL_HIGH: rdata_nxt = sclh_r;
				gbr_pkg::OFS_TIMEOUT: rdata_nxt = to_r;
				gbr_pkg::OFS_RESULT: rdata_nxt = {gbr_pkg::RESULT_FILL, stat_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// register storage
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			mode_r <= {gbr_pkg::RST_MODE, gbr_pkg::RST_MODE};
			latch_r <= gbr_pkg::RST_PIN_LATCH;
			own_r <= gbr_pkg::RST_OWN_ADDR;
			sclh_r <= gbr_pkg::RST_SCL_COUNT;
			scll_r <= gbr_pkg::RST_SCL_COUNT;
			to_r <= gbr_pkg::RST_TIMEOUT;
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			latch_r <= latch_nxt;
			own_r <= own_nxt;
			sclh_r <= sclh_nxt;
			scll_r <= scll_nxt;
			to_r <= to_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// ----------------------------------------
	// pin drivers
	// ----------------------------------------
	// per-pin drive from mode and latch
	always_comb begin
		gout_nxt = 8'h00;
		goe_nxt = 8'h00;
		gpu_nxt = 8'h00;
		for (int i = 0; i < 8; i++) begin
			case (pin_mode(mode_r, i))
				gbr_pkg::MODE_QUASI: begin
					goe_nxt[i] = ~latch_r[i]; // strong low, weak high
					gpu_nxt[i] = 1'b1;
				end
				gbr_pkg::MODE_INPUT: goe_nxt[i] = 1'b0;
				gbr_pkg::MODE_PUSH: begin
					gout_nxt[i] = latch_r[i];
					goe_nxt[i] = 1'b1;
				end
				gbr_pkg::MODE_OPEN: goe_nxt[i] = ~latch_r[i];
				default: goe_nxt[i] = 1'b0;
			endcase
		end
	end

	// registered pin drive
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			gout_r <= 8'h00;
			goe_r <= 8'h00;
			gpu_r <= 8'h00;
		end else begin
			gout_r <= gout_nxt;
			goe_r <= goe_nxt;
			gpu_r <= gpu_nxt;
		end
	end

	// ----------------------------------------
	// reference dividers
	// ----------------------------------------
	// half-reference tick and 57600 Hz time-out tick
	always_comb begin
		acc_nxt = acc_r + gbr_pkg::HALF_INC;
		half_tick_nxt = 1'b0;
		pre_nxt = pre_r;
		to_tick_nxt = 1'b0;
		if (acc_nxt >= gbr_pkg::ACC_MOD) begin
			acc_nxt = acc_nxt - gbr_pkg::ACC_MOD;
			half_tick_nxt = 1'b1;
			pre_nxt = pre_r + 6'h01;
			to_tick_nxt = (pre_r == gbr_pkg::TO_PRESCALE);
		end
	end

	// divider state
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			acc_r <= 26'h0000000;
			half_tick_r <= 1'b0;
			pre_r <= 6'h00;
			to_tick_r <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			half_tick_r <= half_tick_nxt;
			pre_r <= pre_nxt;
			to_tick_r <= to_tick_nxt;
		end
	end

	// ----------------------------------------
	// bus master
	// ----------------------------------------
	// phase lengths, clamped to the least sum
	assign scl_sum = {1'b0, sclh_r} + {1'b0, scll_r};
	assign hi_cnt = (scl_sum < gbr_pkg::MIN_SCL_SUM) ? gbr_pkg::MIN_SCL_HALF : sclh_r;
	assign lo_cnt = (scl_sum < gbr_pkg::MIN_SCL_SUM) ? gbr_pkg::MIN_SCL_HALF : scll_r;

	// bit sequencer, result and time-out
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		bit_nxt = bit_r;
		shf_nxt = shf_r;
		dat_nxt = dat_r;
		byte_nxt = byte_r;
		res_nxt = res_r;
		stat_nxt = stat_r;
		scl_oe_nxt = scl_oe_r;
		sda_oe_nxt = sda_oe_r;
		tmo_nxt = tmo_r;
		case (st_r)
			gbr_pkg::ST_IDLE: begin
				if (XFER_GO) begin
					sda_oe_nxt = 1'b1; // start condition
					st_nxt = gbr_pkg::ST_START;
					cnt_nxt = hi_cnt;
					shf_nxt = XFER_SLAVE;
					dat_nxt = XFER_DATA;
					byte_nxt = 1'b0;
					bit_nxt = 4'h0;
				end
			end
			gbr_pkg::ST_START: begin
				if (half_tick_r) begin
					if (cnt_r <= 8'h01) begin
						scl_oe_nxt = 1'b1;
						sda_oe_nxt = ~shf_r[7];
						st_nxt = gbr_pkg::ST_LOW;
						cnt_nxt = lo_cnt;
					end else begin
						cnt_nxt = cnt_r - 8'h01;
					end
				end
			end
			gbr_pkg::ST_LOW: begin
				if (half_tick_r) begin
					if (cnt_r <= 8'h01) begin
						scl_oe_nxt = 1'b0;
						st_nxt = gbr_pkg::ST_HIGH;
						cnt_nxt = hi_cnt;
					end else begin
						cnt_nxt = cnt_r - 8'h01;
					end
				end
			end
			gbr_pkg::ST_HIGH: begin
				if (half_tick_r && scl_s2_r) begin
					if (cnt_r > 8'h01) begin
						cnt_nxt = cnt_r - 8'h01;
					end else begin
						scl_oe_nxt = 1'b1;
						cnt_nxt = lo_cnt;
						st_nxt = gbr_pkg::ST_LOW;
						if (bit_r == gbr_pkg::ACK_BIT) begin
							if (sda_s2_r || byte_r) begin
								if (sda_s2_r)
									res_nxt = byte_r ? gbr_pkg::RES_DATA_REFUSED : gbr_pkg::RES_ADDR_REFUSED;
								else
									res_nxt = gbr_pkg::RES_OK;
								sda_oe_nxt = 1'b1;
								st_nxt = gbr_pkg::ST_STOP_L;
							end else begin
								byte_nxt = 1'b1;
								shf_nxt = dat_r;
								bit_nxt = 4'h0;
								sda_oe_nxt = ~dat_r[7];
							end
						end else begin
							bit_nxt = bit_r + 4'h1;
							shf_nxt = {shf_r[6:0], 1'b0};
							sda_oe_nxt = (bit_r == 4'h7) ? 1'b0 : ~shf_r[6];
						end
					end
				end
			end
			gbr_pkg::ST_STOP_L: begin
				if (half_tick_r) begin
					if (cnt_r <= 8'h01) begin
						scl_oe_nxt = 1'b0;
						st_nxt = gbr_pkg::ST_STOP_H;
						cnt_nxt = hi_cnt;
					end else begin
						cnt_nxt = cnt_r - 8'h01;
					end
				end
			end
			gbr_pkg::ST_STOP_H: begin
				if (half_tick_r && scl_s2_r) begin
					if (cnt_r <= 8'h01) begin
						sda_oe_nxt = 1'b0; // stop condition
						st_nxt = gbr_pkg::ST_IDLE;
						stat_nxt = res_r;
					end else begin
						cnt_nxt = cnt_r - 8'h01;
					end
				end
			end
			default: begin
				st_nxt = gbr_pkg::ST_IDLE;
				scl_oe_nxt = 1'b0;
				sda_oe_nxt = 1'b0;
			end
		endcase
		// watchdog on a held-low clock line
		if (st_r != gbr_pkg::ST_IDLE) begin
			if (st_nxt != st_r) begin
				tmo_nxt = {to_r[7:1], 8'h00};
			end else if (to_r[gbr_pkg::TO_EN_BIT] && !scl_s2_r && to_tick_r) begin
				if (tmo_r == 15'h0000) begin
					st_nxt = gbr_pkg::ST_IDLE;
					scl_oe_nxt = 1'b0;
					sda_oe_nxt = 1'b0;
					stat_nxt = gbr_pkg::RES_TIMEOUT;
				end else begin
					tmo_nxt = tmo_r - 15'h0001;
				end
			end
		end
		// busy follows the state that is about to be registered
		busy_nxt = (st_nxt != gbr_pkg::ST_IDLE);
	end

	// bus master state
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			st_r <= gbr_pkg::ST_IDLE;
			cnt_r <= 8'h00;
			bit_r <= 4'h0;
			shf_r <= 8'h00;
			dat_r <= 8'h00;
			byte_r <= 1'b0;
			res_r <= gbr_pkg::RES_OK;
			stat_r <= gbr_pkg::RES_OK;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			tmo_r <= 15'h0000;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
			shf_r <= shf_nxt;
			dat_r <= dat_nxt;
			byte_r <= byte_nxt;
			res_r <= res_nxt;
			stat_r <= stat_nxt;
			scl_oe_r <= scl_oe_nxt;
			sda_oe_r <= sda_oe_nxt;
			tmo_r <= tmo_nxt;
			busy_r <= busy_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// straight from flops except the bus drive values, tied low; bus lines only ever pull low
	assign REG_RDATA = rdata_r;
	assign REG_RVALID = rvalid_r;
	assign XFER_BUSY = busy_r;
	assign GPIO_OUT = gout_r;
	assign GPIO_OE = goe_r;
	assign GPIO_PU = gpu_r;
	assign SCL_OUT = 1'b0;
	assign SCL_OE = scl_oe_r;
	assign SDA_OUT = 1'b0;
	assign SDA_OE = sda_oe_r;
endmodule : gbr_regs

// ### verif/gbr_bus_slave.sv
// Purpose: behavioural two-wire slave on pulled-up lines
// Assumes: master only pulls lines low
// Notes: acks each ninth clock unless told to refuse; can hold the clock low
`timescale 1ns/100ps
module gbr_bus_slave (
	input wire logic scl_oe, // master clock pull
	input wire logic sda_oe, // master data pull
	input wire logic nack_a, // refuse address byte
	input wire logic nack_d, // refuse data byte
	input wire logic hold, // stretch clock low
	output logic scl, // clock line level
	output logic sda // data line level
);
	// ----------------------------------------
	// wired lines and bit counting
	// ----------------------------------------
	int bits = 0;
	int bytes = 0;
	logic pull = 1'b0;
	assign scl = !(scl_oe || hold);
	assign sda = !(sda_oe || pull);
	// start condition restarts the count; the wait skips data that moves with the clock fall
	always @(negedge sda) begin
		#1;
		if (scl && !sda) begin
			bits = 0;
			bytes = 0;
		end
	end
	always @(posedge scl) bits = bits + 1;
	// drive ack through the ninth clock
	always @(negedge scl) begin
		pull = bits == 8 && !((bytes == 0) ? nack_a : nack_d);
		if (bits == 9) begin
			bits = 0;
			bytes = bytes + 1;
		end
	end
endmodule : gbr_bus_slave

// ### verif/gbr_regs_monitor.sv
// Purpose: port checks of the pin drive and two-wire master bank
// Assumes: register writes land at the strobe edge, pin drive follows one edge later
// Notes: shadow copies of the writable registers give the expected drive
`timescale 1ns/100ps
module gbr_regs_monitor (
	input wire logic CLK, // clock
	input wire logic SYS_RST, // reset
	input wire logic REG_WE, // write strobe
	input wire logic REG_RE, // read strobe
	input wire logic [7:0] REG_ADDR, // offset
	input wire logic [7:0] REG_WDATA, // write data
	input wire logic [7:0] REG_RDATA, // read data
	input wire logic XFER_BUSY, // busy
	input wire logic [7:0] GPIO_IN, // pins
	input wire logic [7:0] GPIO_OUT, // drive value
	input wire logic [7:0] GPIO_OE, // drive enable
	input wire logic [7:0] GPIO_PU, // pull-up
	input wire logic SCL_IN, // clock line
	input wire logic SCL_OE, // clock pull
	input wire logic SDA_OE // data pull
);
	// ----------------------------------------
	// shadow registers, expected drive, phase counters
	// ----------------------------------------
	logic [7:0] sh_r [2:9];
	logic [7:0] sh_nxt [2:9];
	logic [23:0] exp_nxt, d1_r;
	logic [1:0] set_r, set_nxt, md;
	logic [11:0] lo_r, lo_nxt, hi_r, hi_nxt;
	// next shadow and drive per pin
	always_comb begin
		sh_nxt = sh_r;
		if (REG_WE && REG_ADDR >= 8'h02 && REG_ADDR <= 8'h09) sh_nxt[REG_ADDR[3:0]] = REG_WDATA;
		for (int k = 0; k < 8; k++) begin
			md = (k < 4) ? sh_r[2][2*k +: 2] : sh_r[3][2*k-8 +: 2];
			exp_nxt[k] = md == gbr_pkg::MODE_PUSH || (md != gbr_pkg::MODE_INPUT && !sh_r[4][k]);
			exp_nxt[8+k] = md == gbr_pkg::MODE_PUSH && sh_r[4][k];
			exp_nxt[16+k] = md == gbr_pkg::MODE_QUASI;
		end
		set_nxt = (set_r == 2'h3) ? set_r : set_r + 2'h1;
		lo_nxt = SCL_OE ? lo_r + 12'h001 : 12'h000;
		// high time counts only while the line is really high: stretching pauses it
		hi_nxt = (SCL_OE || !XFER_BUSY) ? 12'h000 : (SCL_IN ? hi_r + 12'h001 : hi_r);
	end
	// register helpers
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sh_r[2] <= gbr_pkg::RST_MODE;
			sh_r[3] <= gbr_pkg::RST_MODE;
			sh_r[4] <= gbr_pkg::RST_PIN_LATCH;
			sh_r[6] <= gbr_pkg::RST_OWN_ADDR;
			sh_r[7] <= gbr_pkg::RST_SCL_COUNT;
			sh_r[8] <= gbr_pkg::RST_SCL_COUNT;
			sh_r[9] <= gbr_pkg::RST_TIMEOUT;
			d1_r <= 24'h000000;
			set_r <= 2'h0;
			lo_r <= 12'h000;
			hi_r <= 12'h000;
		end else begin
			sh_r <= sh_nxt;
			d1_r <= exp_nxt;
			set_r <= set_nxt;
			lo_r <= lo_nxt;
			hi_r <= hi_nxt;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_rd(a);
		REG_RE && REG_ADDR == a;
	endsequence
	property p_drive_oe; set_r == 2'h3 |-> GPIO_OE == d1_r[7:0]; endproperty
	a_drive_oe: assert property (p_drive_oe) else $error("pin enable wrong");
	property p_drive_out; set_r == 2'h3 |-> (GPIO_OUT & GPIO_OE) == d1_r[15:8]; endproperty
	a_drive_out: assert property (p_drive_out) else $error("pin value wrong");
	property p_drive_pu; set_r == 2'h3 |-> GPIO_PU == d1_r[23:16]; endproperty
	a_drive_pu: assert property (p_drive_pu) else $error("pull-up wrong");
	property p_pin_read; s_rd(gbr_pkg::OFS_PIN_LEVEL) |=> REG_RDATA == $past(GPIO_IN, 3); endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin read wrong");
	property p_fill; s_rd(gbr_pkg::OFS_RESULT) |=> REG_RDATA[7:4] == gbr_pkg::RESULT_FILL; endproperty
	a_fill: assert property (p_fill) else $error("result fill wrong");
	property p_te_off; XFER_BUSY && !sh_r[9][0] && !SCL_IN && !SCL_OE |=> XFER_BUSY; endproperty
	a_te_off: assert property (p_te_off) else $error("time-out while disabled");
	property p_low;
		$fell(SCL_OE) && XFER_BUSY |-> lo_r >= 12'(sh_r[7]) * 12'h00A && lo_r <= 12'(sh_r[7]) * 12'h00B + 12'h001;
	endproperty
	a_low: assert property (p_low) else $error("low phase length wrong");
	property p_high;
		$rose(SCL_OE) && XFER_BUSY |-> hi_r + 12'h00A >= 12'(sh_r[8]) * 12'h00A &&
			hi_r <= 12'(sh_r[8]) * 12'h00B + 12'h004;
	endproperty
	a_high: assert property (p_high) else $error("high phase length wrong");
	property p_idle; !XFER_BUSY && !$past(XFER_BUSY) |-> !SCL_OE && !SDA_OE; endproperty
	a_idle: assert property (p_idle) else $error("lines held while idle");
endmodule : gbr_regs_monitor

bind gbr_regs gbr_regs_monitor u_mon (.CLK(CLK), .SYS_RST(SYS_RST), .REG_WE(REG_WE), .REG_RE(REG_RE),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .XFER_BUSY(XFER_BUSY),
	.GPIO_IN(GPIO_IN), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE), .GPIO_PU(GPIO_PU), .SCL_IN(SCL_IN),
	.SCL_OE(SCL_OE), .SDA_OE(SDA_OE));

// ### verif/tb_gbr_regs.sv
// Purpose: self-checking bench of the pin and bus-master register bank
// Assumes: pins resolve from drive, pull-up and an external level
// Notes: table rows for pin modes and transfers, reset checks after a second reset
`timescale 1ns/100ps
module tb_gbr_regs;
	logic CLK = 1'b0;
	logic SYS_RST = 1'b1;
	logic REG_WE = 1'b0;
	logic REG_RE = 1'b0;
	logic XFER_GO = 1'b0;
	logic [7:0] REG_ADDR = 8'h00;
	logic [7:0] REG_WDATA = 8'h00;
	logic [7:0] ext = 8'h00;
	logic [7:0] REG_RDATA, GPIO_IN, GPIO_OUT, GPIO_OE, GPIO_PU, rd_v;
	logic REG_RVALID, XFER_BUSY, SCL_IN, SCL_OUT, SCL_OE, SDA_IN, SDA_OUT, SDA_OE;
	logic nack_a = 1'b0;
	logic nack_d = 1'b0;
	logic hold = 1'b0;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	// mode lo, mode hi, latch, external, oe, out, pull-up, read
	logic [63:0] pin_rows [5] = '{64'h00000F00F000FF0F, 64'h5555FFA50000_00A5, 64'hAAAA3CFFFF3C003C,
		64'hFFFF3C0FC300000C, 64'hE41B00FFBD008142};
	logic [15:0] reg_rows [9] = '{16'h0200, 16'h0300, 16'h0500, 16'h0600, 16'h070A, 16'h080A, 16'h0900,
		16'h0AF0, 16'h0B00};
	// refuse address, refuse data, stretch, time-out register, result code
	logic [15:0] xfer_rows [6] = '{16'h0000, 16'h0FF0, 16'h4001, 16'h2002, 16'h1018, 16'h1000};
	// ----------------------------------------
	// clock, pins, instances
	// ----------------------------------------
	initial forever #12.5 CLK = !CLK;
	always_comb for (int k = 0; k < 8; k++) GPIO_IN[k] = GPIO_OE[k] ? GPIO_OUT[k] : (GPIO_PU[k] | ext[k]);
	gbr_regs dut (.CLK(CLK), .SYS_RST(SYS_RST), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_ADDR(REG_ADDR),
		.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .XFER_GO(XFER_GO),
		.XFER_SLAVE(8'hA6), .XFER_DATA(8'h5C), .XFER_BUSY(XFER_BUSY), .GPIO_IN(GPIO_IN), .GPIO_OUT(GPIO_OUT),
		.GPIO_OE(GPIO_OE), .GPIO_PU(GPIO_PU), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
		.SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE));
	gbr_bus_slave u_slave (.scl_oe(SCL_OE), .sda_oe(SDA_OE), .nack_a(nack_a), .nack_d(nack_d), .hold(hold),
		.scl(SCL_IN), .sda(SDA_IN));
	task automatic final_report;
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick(1);
		REG_WE = 1'b1;
		REG_ADDR = a;
		REG_WDATA = d;
		tick(1);
		REG_WE = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		tick(1);
		REG_RE = 1'b1;
		REG_ADDR = a;
		tick(1);
		REG_RE = 1'b0;
		d = REG_RVALID ? REG_RDATA : 8'hXX;
	endtask : rd
	// cycle ceiling cuts a hang short
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			final_report();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		tick(20);
		SYS_RST = 1'b0;
		for (int i = 0; i < 5; i++) begin
			ext = pin_rows[i][39:32];
			wr(8'h02, pin_rows[i][63:56]);
			wr(8'h03, pin_rows[i][55:48]);
			wr(8'h04, pin_rows[i][47:40]);
			tick(3);
			chk(GPIO_OE, pin_rows[i][31:24]);
			chk(GPIO_OUT & GPIO_OE, pin_rows[i][23:16]);
			chk(GPIO_PU, pin_rows[i][15:8]);
			rd(8'h04, rd_v);
			chk(rd_v, pin_rows[i][7:0]);
		end
		SYS_RST = 1'b1;
		tick(20);
		SYS_RST = 1'b0;
		wr(8'h0A, 8'h00);
		for (int i = 0; i < 9; i++) begin
			rd(reg_rows[i][15:8], rd_v);
			chk(rd_v, reg_rows[i][7:0]);
		end
		chk(GPIO_OE, 8'h00);
		chk(GPIO_PU, 8'hFF);
		chk({6'h00, SCL_OUT, SDA_OUT}, 8'h00);
		wr(8'h06, 8'hA4);
		rd(8'h06, rd_v);
		chk(rd_v, 8'hA4);
		wr(8'h07, 8'h0C);
		wr(8'h08, 8'h08);
		for (int i = 0; i < 6; i++) begin
			{nack_a, nack_d} = xfer_rows[i][14:13];
			wr(8'h09, xfer_rows[i][11:4]);
			tick(1);
			XFER_GO = 1'b1;
			tick(1);
			XFER_GO = 1'b0;
			if (xfer_rows[i][12]) begin
				// stretch only while the master pulls the clock, so no clock edge is lost
				while (SCL_OE !== 1'b1) tick(1);
				hold = 1'b1;
				tick(2000);
				chk({7'h00, XFER_BUSY}, {7'h00, !xfer_rows[i][4]});
				hold = 1'b0;
			end
			while (XFER_BUSY !== 1'b0) tick(1);
			rd(8'h0A, rd_v);
			chk(rd_v, {4'hF, xfer_rows[i][3:0]});
		end
		final_report();
	end
endmodule : tb_gbr_regs
